/* File: rtl/fic_irq_ctrl.sv */
`timescale 1ns/1ps
// Purpose: Enable, pending, active and priority state of the fast interrupt controller
// Assumes: Register port with one-cycle read latency; core acknowledges entry and return
// Notes: Interrupts below 12 have no bits and are never forwarded
module fic_irq_ctrl #(
    parameter int NUM_IRQ = 36
) (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RESET,
    // Register port
    input  wire logic [7:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [31:0] RDATA,
    // Peripheral request pulses, set pending
    input  wire logic [NUM_IRQ-1:0] IRQ_IN,
    // Core handshake
    input  wire logic        CORE_ACK,
    input  wire logic        CORE_RET,
    output logic             IRQ_REQ,
    output logic [7:0]       IRQ_ID,
    output logic [1:0]       NEST_DEPTH
);
    logic [NUM_IRQ-1:0] enable_ff, pending_ff, active_ff;
    logic [NUM_IRQ-1:0] nxt_enable, nxt_pending, nxt_active;
    logic [1:0]         depth_ff, nxt_depth;
    logic [7:0]         stk0_ff, stk1_ff;
    logic [3:0]         lvl0_ff, req_lvl_ff;

    // Decode
    wire        wr_eset_lo = WR && ADDR == fic_pkg::ADR_EN_SET_LO;
    wire        wr_eset_hi = WR && ADDR == fic_pkg::ADR_EN_SET_HI;
    wire        wr_eclr_lo = WR && ADDR == fic_pkg::ADR_EN_CLR_LO;
    wire        wr_eclr_hi = WR && ADDR == fic_pkg::ADR_EN_CLR_HI;
    wire        wr_pset_lo = WR && ADDR == fic_pkg::ADR_PND_SET_LO;
    wire        wr_pset_hi = WR && ADDR == fic_pkg::ADR_PND_SET_HI;
    wire        wr_pclr_lo = WR && ADDR == fic_pkg::ADR_PND_CLR_LO;
    wire        wr_pclr_hi = WR && ADDR == fic_pkg::ADR_PND_CLR_HI;
    wire        prio_sel   = ADDR[7:6] == fic_pkg::ADR_PRIO_BASE[7:6];

    // Map a low/high word pair onto the interrupt vector
    function automatic logic [NUM_IRQ-1:0] to_vec(input logic lo, input logic hi,
                                                   input logic [31:0] d);
        logic [63:0] w;
        w = {(hi ? d & fic_pkg::HI_MASK : 32'h0), (lo ? d & fic_pkg::LO_MASK : 32'h0)};
        return w[NUM_IRQ-1:0];
    endfunction

    function automatic logic [31:0] word_of(input logic [NUM_IRQ-1:0] v, input logic hi);
        logic [63:0] w;
        w = 64'(v);
        return hi ? w[63:32] & fic_pkg::HI_MASK : w[31:0] & fic_pkg::LO_MASK;
    endfunction

    // Sources below 12 have no pending bit, so their pulses are dropped here
    wire [NUM_IRQ-1:0] valid_m = to_vec(1'b1, 1'b1, 32'hffffffff);
    wire [NUM_IRQ-1:0] en_set  = to_vec(wr_eset_lo, wr_eset_hi, WDATA);
    wire [NUM_IRQ-1:0] en_clr  = to_vec(wr_eclr_lo, wr_eclr_hi, WDATA);
    wire [NUM_IRQ-1:0] pnd_set = to_vec(wr_pset_lo, wr_pset_hi, WDATA)
                               | (IRQ_IN & valid_m);
    wire [NUM_IRQ-1:0] pnd_clr = to_vec(wr_pclr_lo, wr_pclr_hi, WDATA);

    // Priority store
    logic [1023:0] levels;
    logic [31:0]   prio_rdata;
    fic_prio_mem #(.WORDS(fic_pkg::NUM_PWORD)) u_prio (
        .clk    (CLK),
        .rst    (RESET),
        .we     (WR && prio_sel),
        .addr   (ADDR[5:0]),
        .wdata  (WDATA),
        .rdata  (prio_rdata),
        .levels (levels)
    );

    // Arbitration over pending and enabled
    wire [NUM_IRQ-1:0] cand = pending_ff & enable_ff & valid_m & ~active_ff;
    logic       found;
    logic [7:0] best_id;
    logic [3:0] best_lvl;
    fic_arbiter #(.N(NUM_IRQ)) u_arb (
        .cand  (cand),
        .level (levels[NUM_IRQ*4-1:0]),
        .found (found),
        .id    (best_id),
        .best  (best_lvl)
    );

    // Preempt only from depth 1 with a strictly more urgent level
    wire can_take = found && (depth_ff == 2'h0 ||
                    (depth_ff == 2'h1 && best_lvl < lvl0_ff));
    wire take     = IRQ_REQ && CORE_ACK;
    wire ret      = CORE_RET && depth_ff != 2'h0;
    wire [7:0] ret_id = depth_ff == 2'h2 ? stk1_ff : stk0_ff;

    always_comb begin
        nxt_enable  = (enable_ff | en_set) & ~en_clr;
        nxt_pending = (pending_ff & ~pnd_clr) | pnd_set;
        nxt_active  = active_ff;
        nxt_depth   = depth_ff;
        if (ret) begin
            nxt_active[ret_id[5:0]] = 1'b0;
            nxt_depth = depth_ff - 2'h1;
        end else if (take) begin
            nxt_active[IRQ_ID[5:0]]  = 1'b1;
            nxt_pending[IRQ_ID[5:0]] = pnd_set[IRQ_ID[5:0]];
            nxt_depth = depth_ff + 2'h1;
        end
    end

    // Priority word as software sees it, low nibble of every slot zero
    function automatic logic [31:0] prio_word(input logic [15:0] nib);
        return {nib[15:12], 4'h0, nib[11:8], 4'h0, nib[7:4], 4'h0, nib[3:0], 4'h0};
    endfunction

    // Read from the flat view so the answer keeps the one-cycle latency of the
    // other words; the store's registered port is kept as a cross-check
    wire [15:0] prio_nib = levels[{ADDR[5:0], 4'h0} +: 16];

    wire [31:0] rd_mux =
        prio_sel                    ? prio_word(prio_nib)      :
        ADDR == fic_pkg::ADR_ACT_LO ? word_of(active_ff, 1'b0) :
        ADDR == fic_pkg::ADR_ACT_HI ? word_of(active_ff, 1'b1) :
        ADDR == fic_pkg::ADR_STATUS ? {30'h0, depth_ff} : 32'h0;
    logic prio_rd_ff;

    // Interrupt state
    always_ff @(posedge CLK) begin
        if (RESET) begin
            enable_ff  <= '0;
            pending_ff <= '0;
            active_ff  <= '0;
            depth_ff   <= 2'h0;
        end else begin
            enable_ff  <= nxt_enable;
            pending_ff <= nxt_pending;
            active_ff  <= nxt_active;
            depth_ff   <= nxt_depth;
        end
    end

    // Return stack; the second level keeps no priority since nothing may
    // preempt it
    always_ff @(posedge CLK) begin
        if (RESET) begin
            stk0_ff <= 8'h00;
            stk1_ff <= 8'h00;
            lvl0_ff <= fic_pkg::PRIO_RESET;
        end else if (take && !ret) begin
            if (depth_ff == 2'h0) begin
                stk0_ff <= IRQ_ID;
                lvl0_ff <= req_lvl_ff;
            end else begin
                stk1_ff <= IRQ_ID;
            end
        end
    end

    // Core side outputs; the level travels with the id so a late priority
    // write cannot change what the stack records
    always_ff @(posedge CLK) begin
        if (RESET) begin
            IRQ_REQ    <= 1'b0;
            IRQ_ID     <= 8'h00;
            req_lvl_ff <= fic_pkg::PRIO_RESET;
            NEST_DEPTH <= 2'h0;
        end else begin
            // Request drops for one cycle after a take so the new depth is seen
            IRQ_REQ    <= can_take && !take && !ret;
            IRQ_ID     <= best_id;
            req_lvl_ff <= best_lvl;
            NEST_DEPTH <= nxt_depth;
        end
    end

    // Register read port
    always_ff @(posedge CLK) begin
        if (RESET) begin
            RDATA      <= fic_pkg::RESET_WORD;
            prio_rd_ff <= 1'b0;
        end else begin
            RDATA      <= RD ? rd_mux : fic_pkg::RESET_WORD;
            prio_rd_ff <= RD && prio_sel;
        end
    end

    a_enable_set : assert property (@(posedge CLK) disable iff (RESET)
        wr_eset_lo && WDATA[12] |=> enable_ff[12]) else $error("enable set lost");
    a_enable_clr : assert property (@(posedge CLK) disable iff (RESET)
        wr_eclr_hi && WDATA[0] && !wr_eset_hi |=> !enable_ff[32]) else $error("disable lost");
    a_pend_set : assert property (@(posedge CLK) disable iff (RESET)
        wr_pset_lo && WDATA[20] |=> pending_ff[20]) else $error("pending set lost");
    a_pend_clr : assert property (@(posedge CLK) disable iff (RESET)
        wr_pclr_hi && WDATA[3] && !IRQ_IN[35] |=> !pending_ff[35]) else $error("clear lost");
    a_zero_noeff : assert property (@(posedge CLK) disable iff (RESET)
        wr_eset_lo && WDATA == 32'h0 |=> enable_ff == $past(enable_ff))
        else $error("zero write changed enable");
    a_low_unused : assert property (@(posedge CLK) disable iff (RESET)
        enable_ff[11:0] == 12'h0 && pending_ff[11:0] == 12'h0) else $error("low bits set");
    a_depth_limit : assert property (@(posedge CLK) disable iff (RESET)
        depth_ff <= fic_pkg::DEPTH_MAX) else $error("nesting too deep");
    a_no_req_full : assert property (@(posedge CLK) disable iff (RESET)
        depth_ff == 2'h2 |=> !IRQ_REQ) else $error("third level request");
    a_req_cand : assert property (@(posedge CLK) disable iff (RESET)
        IRQ_REQ |-> $past(found)) else $error("request without candidate");
    a_active_take : assert property (@(posedge CLK) disable iff (RESET)
        take && !ret |=> active_ff[$past(IRQ_ID[5:0])]) else $error("active not set");

    // Set and clear words, one bits act
    a_enable_set_hi : assert property (
        @(posedge CLK) disable iff (RESET)
        wr_eset_hi && WDATA[3] |=> enable_ff[35]
    ) else $error("high enable set lost");

    a_enable_clr_lo : assert property (
        @(posedge CLK) disable iff (RESET)
        wr_eclr_lo && WDATA[31] |=> !enable_ff[31]
    ) else $error("low disable lost");

    a_pend_set_hi : assert property (
        @(posedge CLK) disable iff (RESET)
        wr_pset_hi && WDATA[0] |=> pending_ff[32]
    ) else $error("high pending set lost");

    a_pend_clr_lo : assert property (
        @(posedge CLK) disable iff (RESET)
        wr_pclr_lo && WDATA[12] && !IRQ_IN[12] |=> !pending_ff[12]
    ) else $error("low pending clear lost");

    a_pend_source : assert property (
        @(posedge CLK) disable iff (RESET)
        IRQ_IN[35] |=> pending_ff[35]
    ) else $error("source pulse lost");

    // Zero bits of a write leave the state alone
    a_eset_zero_keep : assert property (
        @(posedge CLK) disable iff (RESET)
        wr_eset_lo && !WDATA[31] |=> enable_ff[31] == $past(enable_ff[31])
    ) else $error("enable changed by a zero bit");

    a_eclr_zero_keep : assert property (
        @(posedge CLK) disable iff (RESET)
        wr_eclr_lo && !WDATA[12] |=> enable_ff[12] == $past(enable_ff[12])
    ) else $error("disable by a zero bit");

    a_pset_zero_keep : assert property (
        @(posedge CLK) disable iff (RESET)
        wr_pset_lo && !WDATA[20] && !IRQ_IN[20] && !take
        |=> pending_ff[20] == $past(pending_ff[20])
    ) else $error("pending changed by a zero bit");

    a_pclr_zero_keep : assert property (
        @(posedge CLK) disable iff (RESET)
        wr_pclr_hi && !WDATA[1] && !IRQ_IN[33] && !take
        |=> pending_ff[33] == $past(pending_ff[33])
    ) else $error("pending cleared by a zero bit");

    // Read port
    a_active_read_lo : assert property (
        @(posedge CLK) disable iff (RESET)
        RD && ADDR == fic_pkg::ADR_ACT_LO |=> RDATA == {$past(active_ff[31:12]), 12'h000}
    ) else $error("low active word wrong");

    a_active_read_hi : assert property (
        @(posedge CLK) disable iff (RESET)
        RD && ADDR == fic_pkg::ADR_ACT_HI |=> RDATA == {28'h0, $past(active_ff[35:32])}
    ) else $error("high active word wrong");

    a_prio_read : assert property (
        @(posedge CLK) disable iff (RESET)
        prio_rd_ff |-> RDATA == prio_rdata
    ) else $error("priority read differs from store");

    a_prio_low_zero : assert property (
        @(posedge CLK) disable iff (RESET)
        prio_rd_ff |-> (RDATA & ~fic_pkg::SLOT_MASK) == 32'h0
    ) else $error("priority low nibble not zero");

    a_status_read : assert property (
        @(posedge CLK) disable iff (RESET)
        RD && ADDR == fic_pkg::ADR_STATUS |=> RDATA == {30'h0, $past(depth_ff)}
    ) else $error("status word wrong");

    // Nesting
    a_active_ret : assert property (
        @(posedge CLK) disable iff (RESET)
        ret |=> !active_ff[$past(ret_id[5:0])]
    ) else $error("active not cleared on return");

    a_active_count : assert property (
        @(posedge CLK) disable iff (RESET)
        $countones(active_ff) == int'(depth_ff)
    ) else $error("active bits and depth disagree");

    a_preempt_urgent : assert property (
        @(posedge CLK) disable iff (RESET)
        take && depth_ff == 2'h1 |-> req_lvl_ff < lvl0_ff
    ) else $error("preempted by a less urgent level");

    a_depth_take : assert property (
        @(posedge CLK) disable iff (RESET)
        take && !ret |=> depth_ff == $past(depth_ff) + 2'h1
    ) else $error("depth not raised on take");

    a_depth_ret : assert property (
        @(posedge CLK) disable iff (RESET)
        ret |=> depth_ff == $past(depth_ff) - 2'h1
    ) else $error("depth not lowered on return");

    a_req_depth_ok : assert property (
        @(posedge CLK) disable iff (RESET)
        IRQ_REQ |-> depth_ff != fic_pkg::DEPTH_MAX
    ) else $error("request while nesting is full");
endmodule // fic_irq_ctrl

/* File: common/fic_pkg.sv */
// Purpose: Constants for the per-interrupt enable, pending, active and priority section
// Assumes: 32-bit register port, word index addressing (byte address = 4 * index)
package fic_pkg;
    localparam int          NUM_IRQ      = 36;
    localparam int          IRQ_LO_FIRST = 12;
    localparam int          NUM_PRIO     = 256;
    localparam int          NUM_PWORD    = 64;
    localparam logic [31:0] LO_MASK      = 32'hfffff000;
    localparam logic [31:0] HI_MASK      = 32'h0000000f;
    localparam logic [31:0] SLOT_MASK    = 32'hf0f0f0f0;
    localparam logic [31:0] RESET_WORD   = 32'h00000000;
    localparam logic [3:0]  PRIO_RESET   = 4'h0;
    localparam logic [1:0]  DEPTH_MAX    = 2'h2;
    // Register word indexes
    localparam logic [7:0]  ADR_EN_SET_LO  = 8'h00;
    localparam logic [7:0]  ADR_EN_SET_HI  = 8'h01;
    localparam logic [7:0]  ADR_EN_CLR_LO  = 8'h02;
    localparam logic [7:0]  ADR_EN_CLR_HI  = 8'h03;
    localparam logic [7:0]  ADR_PND_SET_LO = 8'h04;
    localparam logic [7:0]  ADR_PND_SET_HI = 8'h05;
    localparam logic [7:0]  ADR_PND_CLR_LO = 8'h06;
    localparam logic [7:0]  ADR_PND_CLR_HI = 8'h07;
    localparam logic [7:0]  ADR_ACT_LO     = 8'h08;
    localparam logic [7:0]  ADR_ACT_HI     = 8'h09;
    localparam logic [7:0]  ADR_STATUS     = 8'h0a;
    localparam logic [7:0]  ADR_PRIO_BASE  = 8'h40;
endpackage

/* File: rtl/fic_prio_mem.sv */
`timescale 1ns/1ps
// Purpose: Priority slot store, one 32-bit word per four interrupts
// Assumes: Single write port, registered read port plus flat view of all slots
// Notes: Low nibbles are never stored
module fic_prio_mem #(
    parameter int WORDS = 64
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // Access
    input  wire logic                 we,
    input  wire logic [5:0]           addr,
    input  wire logic [31:0]          wdata,
    output logic      [31:0]          rdata,
    // Flat view, nibble per slot
    output logic      [WORDS*16-1:0]  levels
);
    logic [15:0] mem_ff [WORDS];

    genvar g;
    generate
        for (g = 0; g < WORDS; g++) begin : g_word
            always_ff @(posedge clk) begin
                if (rst) begin
                    mem_ff[g] <= {4{fic_pkg::PRIO_RESET}};
                end else if (we && addr == 6'(g)) begin
                    mem_ff[g] <= {wdata[31:28], wdata[23:20], wdata[15:12], wdata[7:4]};
                end
            end
            assign levels[g*16 +: 16] = mem_ff[g];
        end
    endgenerate

    logic [15:0] rd_word;
    assign rd_word = mem_ff[addr];

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= fic_pkg::RESET_WORD;
        end else begin
            rdata <= {rd_word[15:12], 4'h0, rd_word[11:8], 4'h0,
                      rd_word[7:4], 4'h0, rd_word[3:0], 4'h0};
        end
    end
endmodule // fic_prio_mem

/* File: rtl/fic_arbiter.sv */
`timescale 1ns/1ps
// Purpose: Picks the most urgent candidate among pending and enabled interrupts
// Assumes: Candidates are numbered 0..N-1, levels are four bits each
// Notes: Ties go to the lowest number; purely combinational
module fic_arbiter #(
    parameter int N = 36
) (
    // Candidates
    input  wire logic [N-1:0]   cand,
    input  wire logic [N*4-1:0] level,
    // Result
    output logic                found,
    output logic [7:0]          id,
    output logic [3:0]          best
);
    always_comb begin
        found = 1'b0;
        id    = 8'h00;
        best  = 4'hf;
        for (int i = 0; i < N; i++) begin
            if (cand[i] && (!found || level[i*4 +: 4] < best)) begin
                found = 1'b1;
                id    = 8'(i);
                best  = level[i*4 +: 4];
            end
        end
    end
endmodule // fic_arbiter

/* File: dv/fic_core_model.sv */
`timescale 1ns/1ps
// Purpose: Core side partner, takes forwarded interrupts and returns from service
// Assumes: Acks only while the bench allows it, after a chosen delay
// Notes: Holds off three cycles after an ack because the request line is registered
module fic_core_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Controller side
    input  wire logic       irq_req,
    output logic            core_ack,
    output logic            core_ret,
    // Bench control
    input  wire logic       ack_en,
    input  wire logic [3:0] ack_delay,
    input  wire logic       ret_cmd
);
    logic [3:0] cnt_ff;
    logic [1:0] hold_ff;

    always_ff @(posedge clk) begin
        core_ack <= 1'b0;
        core_ret <= ret_cmd & ~rst;
        if (rst) begin
            cnt_ff  <= 4'h0;
            hold_ff <= 2'h0;
        end else if (hold_ff != 2'h0) begin
            hold_ff <= hold_ff - 2'h1;
        end else if (ack_en && irq_req) begin
            if (cnt_ff >= ack_delay) begin
                core_ack <= 1'b1;
                hold_ff  <= 2'h3;
                cnt_ff   <= 4'h0;
            end else begin
                cnt_ff <= cnt_ff + 4'h1;
            end
        end
    end
endmodule // fic_core_model

/* File: dv/fic_irq_ctrl_tb.sv */
`timescale 1ns/1ps
// Purpose: Self-checking bench for the enable, pending, active and priority section
// Assumes: Core model acks on command; registers reached through the word-index port
// Notes: Random register traffic from a fixed seed, nesting walked by hand
module fic_irq_ctrl_tb;
    logic        CLK, RESET, WR, RD, IRQ_REQ, core_ack, core_ret, ack_en, ret_cmd;
    logic [7:0]  ADDR, IRQ_ID;
    logic [31:0] WDATA, RDATA, d;
    logic [35:0] IRQ_IN, en, pnd;
    logic [1:0]  NEST_DEPTH;
    logic [3:0]  ack_delay;
    logic [3:0]  lvl [0:35];
    int          fails, cmp_count;

    fic_irq_ctrl #(.NUM_IRQ(36)) dut_u (.CLK(CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ_IN(IRQ_IN), .CORE_ACK(core_ack),
        .CORE_RET(core_ret), .IRQ_REQ(IRQ_REQ), .IRQ_ID(IRQ_ID), .NEST_DEPTH(NEST_DEPTH));
    fic_core_model core_u (.clk(CLK), .rst(RESET), .irq_req(IRQ_REQ), .core_ack(core_ack),
        .core_ret(core_ret), .ack_en(ack_en), .ack_delay(ack_delay), .ret_cmd(ret_cmd));

    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge CLK);
        ADDR  <= a;
        WDATA <= v;
        WR    <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge CLK);
        ADDR <= a;
        RD   <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1 chk("read data", exp, RDATA);
    endtask
    // Mirror of enable and pending state; op follows the register index order
    task automatic update(input int op, input logic [31:0] v);
        logic [35:0] m;
        m = op[0] ? {v[3:0], 32'h0} : {4'h0, v & fic_pkg::LO_MASK};
        case (op / 2)
            0: en = en | m;
            1: en = en & ~m;
            2: pnd = pnd | m;
            default: pnd = pnd & ~m;
        endcase
    endtask
    function automatic logic [8:0] best();
        logic [8:0] r;
        r = 9'h0;
        for (int i = 12; i < 36; i++)
            if (en[i] && pnd[i] && (!r[8] || lvl[i] < lvl[r[7:0]])) r = {1'b1, 8'(i)};
        return r;
    endfunction
    task automatic expect_req();
        logic [8:0] b;
        b = best();
        repeat (4) @(posedge CLK);
        #1 chk("request", {31'h0, b[8]}, {31'h0, IRQ_REQ});
        if (b[8]) chk("forwarded id", {24'h0, b[7:0]}, {24'h0, IRQ_ID});
    endtask
    // Numbers below 12 have no bits, so the mirror ignores them
    task automatic pulse(input int n);
        @(posedge CLK);
        IRQ_IN <= 36'h1 << n;
        @(posedge CLK);
        IRQ_IN <= 36'h0;
        if (n >= 12) pnd[n] = 1'b1;
    endtask
    task automatic take(input logic [3:0] dly);
        ack_delay <= dly;
        ack_en    <= 1'b1;
        for (int k = 0; k < 40 && !core_ack; k++) @(posedge CLK);
        ack_en <= 1'b0;
    endtask
    task automatic depth(input logic [1:0] exp);
        repeat (3) @(posedge CLK);
        #1 chk("nest depth", {30'h0, exp}, {30'h0, NEST_DEPTH});
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        #200us;
        fails++;
        tally_and_finish();
    end

    initial begin
        {WR, RD, ack_en, ret_cmd} = 4'h0;
        ADDR = 8'h0;
        WDATA = 32'h0;
        IRQ_IN = 36'h0;
        ack_delay = 4'h0;
        {en, pnd} = 72'h0;
        fails = 0;
        cmp_count = 0;
        void'($urandom(32'h8976));
        RESET = 1'b1;
        repeat (3) @(posedge CLK);
        RESET <= 1'b0;
        rd(fic_pkg::ADR_ACT_LO, 32'h0);
        rd(fic_pkg::ADR_ACT_HI, 32'h0);
        rd(8'h20, 32'h0);
        for (int x = 0; x < 64; x++) rd(fic_pkg::ADR_PRIO_BASE + 8'(x), 32'h0);
        wr(fic_pkg::ADR_PRIO_BASE + 8'h3f, 32'hffffffff);
        rd(fic_pkg::ADR_PRIO_BASE + 8'h3f, 32'hf0f0f0f0);
        for (int x = 0; x < 64; x++) begin
            d = $urandom();
            wr(fic_pkg::ADR_PRIO_BASE + 8'(x), d);
            rd(fic_pkg::ADR_PRIO_BASE + 8'(x), d & fic_pkg::SLOT_MASK);
            for (int k = 0; k < 4; k++)
                if (4 * x + k < 36) lvl[4 * x + k] = d[8 * k + 4 +: 4];
        end
        pulse(5);
        for (int i = 0; i < 32; i++) begin
            d = $urandom();
            wr(fic_pkg::ADR_EN_SET_LO + 8'(i % 8), d);
            update(i % 8, d);
            if (i % 3 == 0) pulse(12 + int'($urandom_range(23)));
            expect_req();
        end
        wr(fic_pkg::ADR_EN_SET_LO, 32'h0);
        expect_req();
        // Nesting walk: 20 at level 8, 33 at level 4, 14 at level 2, rest at 15
        wr(fic_pkg::ADR_PND_CLR_LO, 32'hffffffff);
        wr(fic_pkg::ADR_PND_CLR_HI, 32'h0000000f);
        wr(fic_pkg::ADR_EN_SET_LO, 32'hffffffff);
        wr(fic_pkg::ADR_EN_SET_HI, 32'h0000000f);
        pnd = 36'h0;
        en = {36{1'b1}};
        for (int x = 3; x < 9; x++) wr(fic_pkg::ADR_PRIO_BASE + 8'(x), 32'hf0f0f0f0);
        wr(fic_pkg::ADR_PRIO_BASE + 8'h05, 32'hf0f0f080);
        wr(fic_pkg::ADR_PRIO_BASE + 8'h08, 32'hf0f040f0);
        wr(fic_pkg::ADR_PRIO_BASE + 8'h03, 32'hf020f0f0);
        for (int i = 12; i < 36; i++) lvl[i] = 4'hf;
        lvl[20] = 4'h8;
        lvl[33] = 4'h4;
        lvl[14] = 4'h2;
        pulse(20);
        expect_req();
        take(4'h0);
        wr(fic_pkg::ADR_PND_CLR_LO, 32'h00100000);
        pnd = 36'h0;
        depth(2'h1);
        rd(fic_pkg::ADR_ACT_LO, 32'h00100000);
        wr(fic_pkg::ADR_PND_SET_HI, 32'h00000002);
        pnd[33] = 1'b1;
        expect_req();
        take(4'h5);
        wr(fic_pkg::ADR_PND_CLR_HI, 32'h00000002);
        pnd = 36'h0;
        depth(2'h2);
        rd(fic_pkg::ADR_ACT_HI, 32'h00000002);
        rd(fic_pkg::ADR_STATUS, 32'h00000002);
        wr(fic_pkg::ADR_PND_SET_LO, 32'h00004000);
        repeat (4) @(posedge CLK);
        #1 chk("request at full depth", 32'h0, {31'h0, IRQ_REQ});
        wr(fic_pkg::ADR_PND_CLR_LO, 32'h00004000);
        for (int r = 0; r < 2; r++) begin
            @(posedge CLK);
            ret_cmd <= 1'b1;
            @(posedge CLK);
            ret_cmd <= 1'b0;
            depth(2'(1 - r));
        end
        rd(fic_pkg::ADR_ACT_LO, 32'h0);
        rd(fic_pkg::ADR_ACT_HI, 32'h0);
        tally_and_finish();
    end
endmodule // fic_irq_ctrl_tb
